// ==== hdl/acs_filter.sv ====
// Decimation filter: counts ones of the modulator stream over a conversion.
// Assumes start, sample and bit_in come from the sequencer's clock domain.
`timescale 1ns/1ps
module acs_filter #(
  parameter int CODE_W = 12,
  parameter int CNT_W  = 11
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic [CNT_W-1:0]  n_samples,
  input  wire logic              sample,
  input  wire logic              bit_in,
  output logic                   done_q,
  output logic [CODE_W-1:0]      code_q
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] ones_q;
  logic [CNT_W-1:0] n_q;
  logic             active_q;
  logic [CNT_W-1:0] ones_d;
  logic             last;

  // ==========================================================
  // Scale ones count to a signed code, clamped to the code range
  function automatic logic [CODE_W-1:0] scale(input logic [CNT_W-1:0] ones,
                                              input logic [CNT_W-1:0] n);
    logic signed [CNT_W+1:0]        diff;
    logic signed [CNT_W+CODE_W+1:0] prod;
    logic signed [CNT_W+CODE_W+1:0] quo;
    diff = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, n});
    prod = (CNT_W+CODE_W+2)'(diff) <<< (CODE_W-1);
    quo  = prod / $signed({{(CODE_W+2){1'b0}}, n});
    if (quo > $signed((CNT_W+CODE_W+2)'((1 << (CODE_W-1)) - 1)))
      return {1'b0, {(CODE_W-1){1'b1}}};
    else if (quo < -$signed((CNT_W+CODE_W+2)'(1 << (CODE_W-1))))
      return {1'b1, {(CODE_W-1){1'b0}}};
    return quo[CODE_W-1:0];
  endfunction : scale

  always_comb begin
    ones_d = ones_q + CNT_W'(bit_in);
    last   = active_q && sample && (cnt_q == n_q - CNT_W'(1));
  end

  // ==========================================================
  // Sample counting; a new start restarts the window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q    <= '0;
      ones_q   <= '0;
      n_q      <= '0;
      active_q <= 1'b0;
    end else if (abort) begin
      active_q <= 1'b0;
    end else if (start) begin
      cnt_q    <= '0;
      ones_q   <= '0;
      n_q      <= n_samples;                 // Rate frozen per conversion
      active_q <= 1'b1;
    end else if (active_q && sample) begin
      cnt_q    <= cnt_q + CNT_W'(1);
      ones_q   <= ones_d;
      active_q <= !last;
    end
  end

  // Code out only when the window is whole
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      code_q <= '0;
    end else begin
      done_q <= last && !abort;
      if (last && !abort)
        code_q <= scale(ones_d, n_q);        // Proportional signed code
    end
  end

  // ==========================================================
  // Checks
  window_len_a: assert property (@(posedge clk) disable iff (!rstn)
    done_q |-> $past(cnt_q) == $past(n_q) - CNT_W'(1))
    else $error("filter window length differs from programmed count");
  no_sample_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !active_q && !start |=> $stable(cnt_q) || abort)
    else $error("filter counted while idle");
endmodule : acs_filter

// ==== hdl/acs_pkg.sv ====
// Types and shared functions of the conversion sequencer.
// Assumes acs_regs.svh on the include path.
package acs_pkg;
  `include "acs_regs.svh"

  // ==========================================================
  // Types
  typedef enum logic {ST_DOWN, ST_CONV} acs_state_type;
  typedef logic [`ACS_SEL_W-1:0]  acs_sel_type;
  typedef logic [`ACS_RATE_W-1:0] acs_rate_type;
  typedef logic [`ACS_CODE_W-1:0] acs_code_type;
  typedef logic [`ACS_CNT_W-1:0]  acs_count_type;
  typedef struct packed {
    logic       gnd;
    logic [1:0] pos;
    logic [1:0] neg;
  } acs_mux_type;

  localparam int ACS_OSC_CYCLES = `ACS_CLK_HZ / `ACS_OSC_HZ;
  localparam int ACS_MOD_CYCLES = ACS_OSC_CYCLES * `ACS_MOD_DIV;
  localparam int ACS_MOD_HZ     = `ACS_OSC_HZ / `ACS_MOD_DIV;

  // ==========================================================
  // Rate code to samples per second; code 7 repeats the top rate
  function automatic int acs_rate_sps(input acs_rate_type r);
    int s;
    s = `ACS_RATE6_SPS;
    unique case (r)
      3'h0: s = `ACS_RATE0_SPS;
      3'h1: s = `ACS_RATE1_SPS;
      3'h2: s = `ACS_RATE2_SPS;
      3'h3: s = `ACS_RATE3_SPS;
      3'h4: s = `ACS_RATE4_SPS;
      3'h5: s = `ACS_RATE5_SPS;
      3'h6: s = `ACS_RATE6_SPS;
      3'h7: s = `ACS_RATE6_SPS;
    endcase
    return s;
  endfunction : acs_rate_sps

  // Modulator samples per conversion, kept strictly inside one period
  function automatic acs_count_type acs_rate_samples(input acs_rate_type r);
    return acs_count_type'((ACS_MOD_HZ - 1) / acs_rate_sps(r));
  endfunction : acs_rate_samples

  // Clock cycles in one output period
  function automatic int acs_rate_period(input acs_rate_type r);
    return `ACS_CLK_HZ / acs_rate_sps(r);
  endfunction : acs_rate_period

  // Selection code to positive/negative input and ground switch
  function automatic acs_mux_type acs_mux_decode(input acs_sel_type s);
    acs_mux_type m;
    m = '{gnd: 1'b1, pos: s[1:0], neg: `ACS_AIN_ZERO};
    unique case (s)
      3'h0: m = '{gnd: 1'b0, pos: `ACS_AIN_ZERO, neg: `ACS_AIN_ONE};
      3'h1: m = '{gnd: 1'b0, pos: `ACS_AIN_ZERO, neg: `ACS_AIN_THREE};
      3'h2: m = '{gnd: 1'b0, pos: `ACS_AIN_ONE,  neg: `ACS_AIN_THREE};
      3'h3: m = '{gnd: 1'b0, pos: `ACS_AIN_TWO,  neg: `ACS_AIN_THREE};
      3'h4, 3'h5, 3'h6, 3'h7: m = '{gnd: 1'b1, pos: s[1:0], neg: `ACS_AIN_ZERO};
    endcase
    return m;
  endfunction : acs_mux_decode
endpackage : acs_pkg

// ==== hdl/acs_regs.svh ====
// Constants of the conversion sequencer: clocks, rates, defaults, input codes.
// Assumes inclusion by the package only; definitions only.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// Clocking
`define ACS_CLK_HZ       100000000
`define ACS_OSC_HZ       1000000
`define ACS_MOD_DIV      4

// ==========================================================
// Data rates in samples per second, by rate_select_field code
`define ACS_RATE0_SPS    128
`define ACS_RATE1_SPS    250
`define ACS_RATE2_SPS    490
`define ACS_RATE3_SPS    920
`define ACS_RATE4_SPS    1600
`define ACS_RATE5_SPS    2400
`define ACS_RATE6_SPS    3300

// ==========================================================
// Field widths and reset values
`define ACS_SEL_W        3
`define ACS_RATE_W       3
`define ACS_CODE_W       12
`define ACS_CNT_W        11
`define ACS_SEL_RST      3'h0
`define ACS_RATE_RST     3'h4
`define ACS_RESULT_RST   12'h000

// ==========================================================
// Analog input numbers on the multiplexer
`define ACS_AIN_ZERO     2'h0
`define ACS_AIN_ONE      2'h1
`define ACS_AIN_TWO      2'h2
`define ACS_AIN_THREE    2'h3

`endif

// ==== hdl/acs_seq.sv ====
// Conversion sequencer: single-shot and continuous conversion control,
// modulator clock divider, input multiplexer control and result holding.
// Assumes host-side logic on clk drives the configuration and request inputs;
// modulator_bit comes from the analog modulator and is resynchronised here.
`timescale 1ns/1ps
module acs_seq
  import acs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 convert_request,
  input  wire logic                 mode_continuous,
  input  wire acs_pkg::acs_sel_type  input_select_field,
  input  wire acs_pkg::acs_rate_type rate_select_field,
  input  wire logic                 general_call_reset,
  input  wire logic                 modulator_bit,
  output acs_pkg::acs_code_type     result_q,
  output logic                      conv_done_q,
  output logic                      busy_q,
  output logic                      powered_down_q,
  output logic                      modulator_clk_q,
  output logic [1:0]                positive_converter_input_q,
  output logic [1:0]                negative_converter_input_q,
  output logic                      neg_ground_q
);
  import acs_pkg::*;

  localparam int OSC_W = $clog2(ACS_OSC_CYCLES);

  acs_state_type state_q;
  acs_state_type state_d;
  acs_rate_type  rate_q;
  acs_sel_type   sel_q;
  acs_mux_type   mux;
  acs_code_type  filt_code;
  logic [OSC_W-1:0] osc_cnt_q;
  logic [1:0]       quarter_q;
  logic             osc_tick;
  logic             mod_tick;
  logic             start_conv;
  logic             filt_done;
  logic             hold_q;
  logic             mode_prev_q;
  logic             bit_meta_q;
  logic             bit_sync_q;

  // ==========================================================
  // Oscillator and modulator tick
  always_comb begin
    osc_tick = osc_cnt_q == OSC_W'(ACS_OSC_CYCLES - 1);
    mod_tick = osc_tick && (quarter_q == 2'(`ACS_MOD_DIV - 1));
    mux      = acs_mux_decode(input_select_field);
  end

  // Divider restarts with each conversion so ticks align to its start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt_q <= '0;
      quarter_q <= '0;
    end else if (start_conv) begin
      osc_cnt_q <= '0;
      quarter_q <= '0;
    end else if (osc_tick) begin
      osc_cnt_q <= '0;
      quarter_q <= quarter_q + 2'h1;
    end else begin
      osc_cnt_q <= osc_cnt_q + OSC_W'(1);
    end
  end

  // Modulator clock runs only while converting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      modulator_clk_q <= 1'b0;
    else
      modulator_clk_q <= (state_q == ST_CONV) && quarter_q[1];
  end

  // ==========================================================
  // Bitstream resynchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_meta_q <= 1'b0;
      bit_sync_q <= 1'b0;
    end else begin
      bit_meta_q <= modulator_bit;
      bit_sync_q <= bit_meta_q;
    end
  end

  // ==========================================================
  // Start decision: request, enabled continuous mode, or back-to-back
  assign start_conv = !general_call_reset &&
    ((state_q == ST_DOWN && (convert_request ||
                             (mode_continuous && !hold_q))) ||
     (state_q == ST_CONV && filt_done && mode_continuous));

  // Hold keeps continuous mode asleep after reset until the host acts;
  // previous mode resets high so a mode held on through reset is no edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q      <= 1'b1;
      mode_prev_q <= 1'b1;
    end else begin
      mode_prev_q <= mode_continuous;
      if (general_call_reset)
        hold_q <= 1'b1;
      else if (convert_request || (mode_continuous && !mode_prev_q))
        hold_q <= 1'b0;
    end
  end

  // ==========================================================
  // Conversion state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_DOWN: if (start_conv) state_d = ST_CONV;
      ST_CONV: if (filt_done && !start_conv) state_d = ST_DOWN;
    endcase
    if (general_call_reset)
      state_d = ST_DOWN;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= ST_DOWN;
      busy_q         <= 1'b0;
      powered_down_q <= 1'b1;
    end else begin
      state_q        <= state_d;
      busy_q         <= state_d == ST_CONV;
      powered_down_q <= state_d == ST_DOWN;
    end
  end

  // ==========================================================
  // Configuration latched at conversion start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q                      <= `ACS_SEL_RST;
      rate_q                     <= `ACS_RATE_RST;
      positive_converter_input_q <= `ACS_AIN_ZERO;
      negative_converter_input_q <= `ACS_AIN_ONE;
      neg_ground_q               <= 1'b0;
    end else if (general_call_reset) begin
      sel_q                      <= `ACS_SEL_RST;
      rate_q                     <= `ACS_RATE_RST;
      positive_converter_input_q <= `ACS_AIN_ZERO;
      negative_converter_input_q <= `ACS_AIN_ONE;
      neg_ground_q               <= 1'b0;
    end else if (start_conv) begin
      sel_q                      <= input_select_field;
      rate_q                     <= rate_select_field;
      positive_converter_input_q <= mux.pos;
      negative_converter_input_q <= mux.neg;
      neg_ground_q               <= mux.gnd;
    end
  end

  // ==========================================================
  // Filter
  acs_filter #(
    .CODE_W (`ACS_CODE_W),
    .CNT_W  (`ACS_CNT_W)
  ) u_filter (
    .clk       (clk),
    .rstn      (rstn),
    .start     (start_conv),
    .abort     (general_call_reset),
    .n_samples (acs_rate_samples(rate_select_field)),
    .sample    (mod_tick),
    .bit_in    (bit_sync_q),
    .done_q    (filt_done),
    .code_q    (filt_code)
  );

  // Result is replaced whole, only by a finished conversion or cleared by a general-call reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_q    <= `ACS_RESULT_RST;
      conv_done_q <= 1'b0;
    end else begin
      conv_done_q <= filt_done && !general_call_reset;
      if (general_call_reset)
        result_q <= `ACS_RESULT_RST;
      else if (filt_done)
        result_q <= filt_code;
    end
  end

  // ==========================================================
  // Checks and their helpers
  int unsigned span_q;
  int unsigned gap_q;

  // Cycles since conversion start, and since last modulator tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      span_q <= 0;
      gap_q  <= 0;
    end else begin
      span_q <= start_conv ? 0 : span_q + 1;
      gap_q  <= (start_conv || mod_tick) ? 0 : gap_q + 1;
    end
  end

  result_whole_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(result_q) |-> conv_done_q || $past(general_call_reset))
    else $error("result changed without a completed conversion");
  single_down_a: assert property (@(posedge clk) disable iff (!rstn)
    conv_done_q && !$past(mode_continuous) |-> powered_down_q)
    else $error("single-shot did not power down after result");
  cont_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    conv_done_q && $past(mode_continuous) |-> busy_q)
    else $error("continuous mode did not restart at once");
  conv_span_a: assert property (@(posedge clk) disable iff (!rstn)
    filt_done |-> span_q < acs_rate_period(rate_q))
    else $error("conversion exceeded one output period");
  cont_rate_a: assert property (@(posedge clk) disable iff (!rstn)
    filt_done |-> span_q == 32'(acs_rate_samples(rate_q)) * ACS_MOD_CYCLES)
    else $error("conversion length differs from programmed rate");
  mod_period_a: assert property (@(posedge clk) disable iff (!rstn)
    mod_tick |-> gap_q == ACS_MOD_CYCLES - 1)
    else $error("modulator tick period is not four oscillator periods");
  gnd_switch_a: assert property (@(posedge clk) disable iff (!rstn)
    start_conv |=> neg_ground_q == $past(input_select_field[2]))
    else $error("ground switch does not follow single-ended selection");
  sel_frozen_a: assert property (@(posedge clk) disable iff (!rstn)
    busy_q && !start_conv && !general_call_reset |=> $stable(sel_q) && $stable(rate_q))
    else $error("configuration changed during a conversion");
  request_runs_a: assert property (@(posedge clk) disable iff (!rstn)
    powered_down_q && convert_request && !general_call_reset |=> busy_q)
    else $error("request did not start a conversion");
  gc_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    general_call_reset |=> powered_down_q && result_q == `ACS_RESULT_RST)
    else $error("general-call reset did not restore defaults");

  single_cov_c: cover property (@(posedge clk) disable iff (!rstn)
    conv_done_q && powered_down_q);
  back_to_back_c: cover property (@(posedge clk) disable iff (!rstn)
    conv_done_q && busy_q);
  gc_abort_c: cover property (@(posedge clk) disable iff (!rstn)
    busy_q && general_call_reset);
endmodule : acs_seq

// ==== tb/acs_modulator_model.sv ====
// Behavioural analog modulator standing at the far side of the sequencer.
// Assumes powered follows the sequencer power state and level is set by the bench.
`timescale 1ns/1ps
module acs_modulator_model (
  input  wire logic clk,
  input  wire logic powered,
  input  wire logic level,
  output logic      bit_out
);
  logic toggle_q = 1'b0;

  // ==========================================================
  // Idle pattern: an unpowered modulator gives a stream that changes every cycle
  always @(posedge clk) begin
    toggle_q <= ~toggle_q;
  end

  // Powered: comparator follows the input level with no settling delay
  assign bit_out = powered ? level : toggle_q;
endmodule : acs_modulator_model

// ==== tb/testbench.sv ====
// Self-checking bench of the conversion sequencer: reset, single-shot, mux codes,
// continuous mode. Assumes acs_pkg compiled first and the modulator model beside it.
`timescale 1ns/1ps
module testbench;
  import acs_pkg::*;

  localparam int SPAN   = ((ACS_MOD_HZ - 1) / 3300) * ACS_MOD_CYCLES;
  localparam int PERIOD = 100000000 / 3300;
  localparam int CEIL   = 100000;

  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         convert_request = 1'b0;
  logic         mode_continuous = 1'b0;
  acs_sel_type  input_select_field = 3'h4;
  acs_rate_type rate_select_field = 3'h6;
  logic         general_call_reset = 1'b0;
  logic         modulator_bit;
  logic         mod_level = 1'b1;
  acs_code_type result_q;
  logic         conv_done_q;
  logic         busy_q;
  logic         powered_down_q;
  logic         modulator_clk_q;
  logic [1:0]   pos_q;
  logic [1:0]   neg_q;
  logic         neg_ground_q;
  int           fails = 0;
  int           compares = 0;
  int           cycles = 0;

  // ==========================================================
  // Clock, design and far-side model
  always #5 clk = ~clk;

  acs_seq acs_seq_inst (
    .clk                        (clk),
    .rstn                       (rstn),
    .convert_request            (convert_request),
    .mode_continuous            (mode_continuous),
    .input_select_field         (input_select_field),
    .rate_select_field          (rate_select_field),
    .general_call_reset         (general_call_reset),
    .modulator_bit              (modulator_bit),
    .result_q                   (result_q),
    .conv_done_q                (conv_done_q),
    .busy_q                     (busy_q),
    .powered_down_q             (powered_down_q),
    .modulator_clk_q            (modulator_clk_q),
    .positive_converter_input_q (pos_q),
    .negative_converter_input_q (neg_q),
    .neg_ground_q               (neg_ground_q)
  );

  acs_modulator_model acs_modulator_model_inst (
    .clk     (clk),
    .powered (~powered_down_q),
    .level   (mod_level),
    .bit_out (modulator_bit)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // One-cycle request pulse; t is the edge that takes it
  task automatic request(output time t);
    @(negedge clk);
    convert_request = 1'b1;
    @(posedge clk);
    t = $time;
    @(negedge clk);
    convert_request = 1'b0;
  endtask : request

  task automatic gc_reset;
    @(negedge clk);
    general_call_reset = 1'b1;
    @(negedge clk);
    general_call_reset = 1'b0;
    @(posedge clk);
    #1;
  endtask : gc_reset

  // Waits for conv_done_q; held drops if result_q leaves hold before it
  task automatic wait_done(input int limit, input acs_code_type hold, output logic held);
    int n;
    n = 0;
    held = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (conv_done_q !== 1'b1 && result_q !== hold) held = 1'b0;
    end while (conv_done_q !== 1'b1 && n < limit);
  endtask : wait_done

  task automatic run_while(input logic v, output int n);
    n = 0;
    while (modulator_clk_q === v && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : run_while

  // ==========================================================
  // Scenarios
  task automatic reset_state;
    check(result_q, 12'h000, "reset result");
    check(powered_down_q, 1'b1, "reset down");
    check({neg_ground_q, pos_q, neg_q}, 5'h01, "reset mux");
    repeat (100) @(posedge clk);
    #1;
    check({busy_q, conv_done_q, modulator_clk_q}, 3'h0, "stays down");
  endtask : reset_state

  // Single-ended single shot at top rate, fields and a request poked mid-run
  task automatic single_shot;
    time  t0;
    time  t1;
    int   hi;
    int   lo;
    logic held;
    request(t0);
    @(posedge clk);
    #1;
    check({busy_q, powered_down_q}, 2'h2, "busy at start");
    check({neg_ground_q, pos_q, neg_q}, 5'h10, "single ended");
    @(negedge clk);
    input_select_field = 3'h1;
    rate_select_field = 3'h0;
    request(t1);
    repeat (4) @(posedge clk);
    #1;
    check({neg_ground_q, pos_q, neg_q}, 5'h10, "mux held");
    run_while(1'b0, lo);
    run_while(1'b1, hi);
    run_while(1'b0, lo);
    check(hi, ACS_MOD_CYCLES / 2, "mod high");
    check(lo, ACS_MOD_CYCLES / 2, "mod low");
    wait_done(SPAN + 10, 12'h000, held);
    check(held, 1'b1, "old result kept");
    check(int'(($time - 1 - t0) / 10), SPAN + 1, "done time");
    check(result_q, 12'h7ff, "full scale");
    check({busy_q, powered_down_q}, 2'h1, "down after");
    held = 1'b1;
    repeat (500) begin
      @(posedge clk);
      #1;
      if (conv_done_q !== 1'b0 || powered_down_q !== 1'b1) held = 1'b0;
    end
    check(held, 1'b1, "one conversion");
  endtask : single_shot

  // Every selection code steers the mux, then a general-call reset aborts
  task automatic mux_codes;
    logic [4:0] exp [8] = '{5'h01, 5'h03, 5'h07, 5'h0b, 5'h10, 5'h14, 5'h18, 5'h1c};
    time        t;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      input_select_field = i[2:0];
      request(t);
      @(posedge clk);
      #1;
      check({neg_ground_q, pos_q, neg_q}, exp[i], "mux code");
      gc_reset();
      check({busy_q, powered_down_q}, 2'h1, "gc abort");
      check(result_q, 12'h000, "gc result");
      check({neg_ground_q, pos_q, neg_q}, 5'h01, "gc mux");
    end
  endtask : mux_codes

  // Back-to-back conversions; the mode is dropped during the second
  task automatic continuous;
    time  t1;
    int   n;
    logic held;
    @(negedge clk);
    input_select_field = 3'h2;
    rate_select_field = 3'h6;
    mod_level = 1'b0;
    mode_continuous = 1'b1;
    wait_done(SPAN + 10, 12'h000, held);
    check(result_q, 12'h800, "negative scale");
    check(busy_q, 1'b1, "restart at once");
    t1 = $time;
    @(negedge clk);
    mod_level = 1'b1;
    mode_continuous = 1'b0;
    wait_done(PERIOD + 10, 12'h800, held);
    check(held, 1'b1, "result steady");
    n = int'(($time - t1) / 10);
    check(n >= SPAN && n <= PERIOD, 1'b1, "rate spacing");
    check(result_q, 12'h7ff, "second result");
    @(posedge clk);
    #1;
    check(powered_down_q, 1'b1, "down after mode off");
    @(negedge clk);
    mode_continuous = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(busy_q, 1'b1, "mode edge starts");
    gc_reset();
    repeat (50) @(posedge clk);
    #1;
    check({busy_q, powered_down_q}, 2'h1, "gc stays down");
    @(negedge clk);
    mode_continuous = 1'b0;
  endtask : continuous

  // ==========================================================
  // Hang guard and main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    @(posedge clk);
    #1;
    reset_state();
    single_shot();
    mux_codes();
    continuous();
    end_of_test();
  end
endmodule : testbench
